// ==== rtl/async_retry_csr_lock_regs.sv ====
// retry limit and lock compare-swap registers behind an apb slave
`timescale 1ns/1ns
`default_nettype none
module async_retry_csr_lock_regs (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // transmit units
  input wire retry_lock_pkg::tx_event_t [2:0] tx_event,
  output retry_lock_pkg::tx_decision_t [2:0] tx_decision,
  // bus-management resources as seen by the link
  output logic [31:0] bus_manager_id,
  output logic [31:0] bandwidth_available,
  output logic [31:0] channels_available_hi,
  output logic [31:0] channels_available_lo,
  // interrupt
  output logic irq
);

  logic rst_meta_q;
  logic rst_n_q;

  // reset release through two flops; assertion stays asynchronous
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  logic setup;
  logic wr_en;
  logic [31:0] retry_q;
  logic [31:0] data_q;
  logic [31:0] compare_q;
  logic complete_q;
  logic [1:0] select_q;
  logic [3:0] irq_status_q;
  logic [3:0] irq_mask_q;
  logic [31:0] resource_q [4];
  logic [31:0] rdata_q;
  logic slverr_q;
  retry_lock_pkg::swap_state_t state_q;
  logic [31:0] current;
  logic match;
  logic swap_start;
  logic [2:0] give_up;

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == retry_lock_pkg::OFS_RETRY)
      || (a == retry_lock_pkg::OFS_DATA)
      || (a == retry_lock_pkg::OFS_COMPARE)
      || (a == retry_lock_pkg::OFS_CONTROL)
      || (a == retry_lock_pkg::OFS_IRQ_STATUS)
      || (a == retry_lock_pkg::OFS_IRQ_MASK);
  endfunction

  function automatic logic wr_hit(input logic en, input logic [7:0] a,
                                  input logic [7:0] ofs);
    wr_hit = en && (a == ofs);
  endfunction

  // zero wait states: read data is latched in the setup cycle
  assign setup = psel && !penable;
  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite;
  assign prdata = rdata_q;
  assign pslverr = slverr_q;

  // read mux, captured at setup so the data output comes from a flop
  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rdata_q <= 32'h0000_0000;
      slverr_q <= 1'b0;
    end else if (setup) begin
      slverr_q <= !is_mapped(paddr);
      case (paddr)
        retry_lock_pkg::OFS_RETRY: rdata_q <= retry_q;
        retry_lock_pkg::OFS_DATA: rdata_q <= data_q;
        retry_lock_pkg::OFS_COMPARE: rdata_q <= compare_q;
        retry_lock_pkg::OFS_CONTROL:
          rdata_q <= {complete_q, 29'h0, select_q}; // R13
        retry_lock_pkg::OFS_IRQ_STATUS: rdata_q <= {28'h0, irq_status_q};
        retry_lock_pkg::OFS_IRQ_MASK: rdata_q <= {28'h000_0000, irq_mask_q};
        default: rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // retry limits; only the low twelve bits hold state
  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      retry_q <= retry_lock_pkg::RETRY_RESET; // R7
    end else if (wr_hit(wr_en, paddr, retry_lock_pkg::OFS_RETRY)) begin
      // R1 R2 R3 bits 31:12 forced to zero
      retry_q <= {20'h0_0000, pwdata[11:0]}; // R4 R5 R6
    end
  end

  // selected resource and comparison
  always_comb begin
    current = resource_q[select_q]; // R12
    match = (current == compare_q); // R9
  end

  // a control write while a swap runs updates the select but starts nothing
  assign swap_start = wr_hit(wr_en, paddr, retry_lock_pkg::OFS_CONTROL)
    && (state_q == retry_lock_pkg::SWAP_IDLE);

  // swap sequencer: one cycle to compare and store
  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q <= retry_lock_pkg::SWAP_IDLE;
    end else begin
      case (state_q)
        retry_lock_pkg::SWAP_IDLE:
          if (swap_start) state_q <= retry_lock_pkg::SWAP_RUN; // R14
        retry_lock_pkg::SWAP_RUN: state_q <= retry_lock_pkg::SWAP_IDLE;
        default: state_q <= retry_lock_pkg::SWAP_IDLE;
      endcase
    end
  end

  // control: select and completion flag; completion wins over a write
  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      complete_q <= retry_lock_pkg::COMPLETE_RESET; // R11
      select_q <= retry_lock_pkg::SELECT_RESET;
    end else begin
      if (wr_hit(wr_en, paddr, retry_lock_pkg::OFS_CONTROL)) begin
        select_q <= pwdata[1:0]; // R12
        complete_q <= 1'b0; // R11
      end
      if (state_q == retry_lock_pkg::SWAP_RUN) complete_q <= 1'b1; // R10
    end
  end

  // data and compare words; the swap returns the prior resource value
  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      data_q <= 32'h0000_0000;
      compare_q <= 32'h0000_0000;
    end else begin
      if (wr_hit(wr_en, paddr, retry_lock_pkg::OFS_DATA)) data_q <= pwdata;
      if (wr_hit(wr_en, paddr, retry_lock_pkg::OFS_COMPARE))
        compare_q <= pwdata;
      if (state_q == retry_lock_pkg::SWAP_RUN) data_q <= current; // R14
    end
  end

  // the four lock resources, one generated flop group each
  genvar r;
  generate
    for (r = 0; r < 4; r++) begin : g_res
      always_ff @(posedge clock or negedge rst_n_q) begin
        if (!rst_n_q) begin
          resource_q[r] <= retry_lock_pkg::RESOURCE_RESET;
        end else if (state_q == retry_lock_pkg::SWAP_RUN
                     && select_q == 2'(r) && match) begin
          resource_q[r] <= data_q; // R8
        end
      end
    end
  endgenerate

  assign bus_manager_id = resource_q[retry_lock_pkg::SEL_BUS_MANAGER_ID];
  assign bandwidth_available =
    resource_q[retry_lock_pkg::SEL_BANDWIDTH_AVAILABLE];
  assign channels_available_hi =
    resource_q[retry_lock_pkg::SEL_CHANNELS_AVAILABLE_HI];
  assign channels_available_lo =
    resource_q[retry_lock_pkg::SEL_CHANNELS_AVAILABLE_LO];

  // one retry counter per transmit unit, each fed its own limit field
  genvar u;
  generate
    for (u = 0; u < retry_lock_pkg::NUM_UNITS; u++) begin : g_unit
      localparam int LSB = retry_lock_pkg::limit_lsb(u);
      retry_counter u_cnt (
        .clock(clock),
        .rst_n(rst_n_q),
        .limit(retry_q[LSB +: 4]), // R4 R5 R6
        .ev(tx_event[u]),
        .dec(tx_decision[u]),
        .count()
      );
      assign give_up[u] = tx_decision[u].give_up;
    end
  endgenerate

  // sticky status, write one to clear; a new event wins over the clear
  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      irq_status_q <= 4'h0;
      irq_mask_q <= 4'h0;
    end else begin
      if (wr_hit(wr_en, paddr, retry_lock_pkg::OFS_IRQ_MASK))
        irq_mask_q <= pwdata[3:0];
      irq_status_q <= (irq_status_q
        & ~(wr_hit(wr_en, paddr, retry_lock_pkg::OFS_IRQ_STATUS)
            ? pwdata[3:0] : 4'h0))
        | {give_up, state_q == retry_lock_pkg::SWAP_RUN};
    end
  end

  assign irq = |(irq_status_q & irq_mask_q);

  // ---- checks ----
  sequence s_ctrl_write;
    wr_hit(wr_en, paddr, retry_lock_pkg::OFS_CONTROL)
      && state_q == retry_lock_pkg::SWAP_IDLE;
  endsequence

  sequence s_swap_run;
    state_q == retry_lock_pkg::SWAP_RUN;
  endsequence

  property p_second_bound_zero;
    @(posedge clock) disable iff (!rst_n_q)
    setup && paddr == retry_lock_pkg::OFS_RETRY |=> rdata_q[31:29] == 3'h0;
  endproperty
  a_second_bound_zero: assert property (p_second_bound_zero) // R1
    else $error("second bound field read nonzero");

  property p_cycle_bound_zero;
    @(posedge clock) disable iff (!rst_n_q)
    setup && paddr == retry_lock_pkg::OFS_RETRY
      |=> rdata_q[28:16] == 13'h0;
  endproperty
  a_cycle_bound_zero: assert property (p_cycle_bound_zero) // R2
    else $error("cycle bound field read nonzero");

  property p_retry_rsvd_zero;
    @(posedge clock) disable iff (!rst_n_q)
    setup && paddr == retry_lock_pkg::OFS_RETRY |=> rdata_q[15:12] == 4'h0;
  endproperty
  a_retry_rsvd_zero: assert property (p_retry_rsvd_zero) // R3
    else $error("retry reserved bits read nonzero");

  property p_phys_limit;
    @(posedge clock) disable iff (!rst_n_q)
    wr_hit(wr_en, paddr, retry_lock_pkg::OFS_RETRY)
      |=> g_unit[0].u_cnt.limit == $past(pwdata[11:8]);
  endproperty
  a_phys_limit: assert property (p_phys_limit) // R4
    else $error("physical response limit not taken");

  property p_resp_limit;
    @(posedge clock) disable iff (!rst_n_q)
    wr_hit(wr_en, paddr, retry_lock_pkg::OFS_RETRY)
      |=> g_unit[1].u_cnt.limit == $past(pwdata[7:4]);
  endproperty
  a_resp_limit: assert property (p_resp_limit) // R5
    else $error("async response limit not taken");

  property p_req_limit;
    @(posedge clock) disable iff (!rst_n_q)
    wr_hit(wr_en, paddr, retry_lock_pkg::OFS_RETRY)
      |=> g_unit[2].u_cnt.limit == $past(pwdata[3:0]);
  endproperty
  a_req_limit: assert property (p_req_limit) // R6
    else $error("async request limit not taken");

  property p_reset_values;
    @(posedge clock) $rose(rst_n_q) |-> retry_q == 32'h0000_0000
      && complete_q;
  endproperty
  a_reset_values: assert property (p_reset_values) // R7
    else $error("retry or control register wrong after reset");

  property p_store_on_match;
    @(posedge clock) disable iff (!rst_n_q)
    s_swap_run and match |=> resource_q[$past(select_q)] == $past(data_q);
  endproperty
  a_store_on_match: assert property (p_store_on_match) // R8
    else $error("matching swap did not store data");

  property p_keep_on_mismatch;
    @(posedge clock) disable iff (!rst_n_q)
    s_swap_run and !match |=> resource_q[$past(select_q)] == $past(current);
  endproperty
  a_keep_on_mismatch: assert property (p_keep_on_mismatch) // R9
    else $error("mismatching swap changed the resource");

  property p_swap_sequence;
    @(posedge clock) disable iff (!rst_n_q)
    s_ctrl_write |=> s_swap_run ##1 complete_q;
  endproperty
  a_swap_sequence: assert property (p_swap_sequence) // R10
    else $error("swap did not complete two cycles after start");

  property p_write_clears;
    @(posedge clock) disable iff (!rst_n_q)
    s_ctrl_write |=> !complete_q;
  endproperty
  a_write_clears: assert property (p_write_clears) // R11
    else $error("control write did not clear the complete flag");

  property p_select_taken;
    @(posedge clock) disable iff (!rst_n_q)
    wr_hit(wr_en, paddr, retry_lock_pkg::OFS_CONTROL)
      |=> select_q == $past(pwdata[1:0]);
  endproperty
  a_select_taken: assert property (p_select_taken) // R12
    else $error("select field not written");

  property p_control_rsvd_zero;
    @(posedge clock) disable iff (!rst_n_q)
    setup && paddr == retry_lock_pkg::OFS_CONTROL
      |=> rdata_q[30:2] == 29'h0;
  endproperty
  a_control_rsvd_zero: assert property (p_control_rsvd_zero) // R13
    else $error("control reserved bits read nonzero");

  property p_prior_returned;
    @(posedge clock) disable iff (!rst_n_q)
    s_ctrl_write ##1 s_swap_run |=> data_q == $past(current);
  endproperty
  a_prior_returned: assert property (p_prior_returned) // R14
    else $error("swap did not return the prior value");

  // the done status must survive a clear written in the same cycle
  property p_done_sets_status;
    @(posedge clock) disable iff (!rst_n_q)
    s_swap_run |=> irq_status_q[retry_lock_pkg::IRQ_SWAP_DONE];
  endproperty
  a_done_sets_status: assert property (p_done_sets_status) // R10
    else $error("finished swap did not set its status bit");

  property p_give_up_sets_status;
    @(posedge clock) disable iff (!rst_n_q)
    give_up != 3'h0 |=> (irq_status_q[3:1] & $past(give_up))
      == $past(give_up);
  endproperty
  a_give_up_sets_status: assert property (p_give_up_sets_status) // R15
    else $error("give up did not set its status bit");

  // only a control write may take the flag down
  property p_complete_stands;
    @(posedge clock) disable iff (!rst_n_q)
    complete_q && !wr_hit(wr_en, paddr, retry_lock_pkg::OFS_CONTROL)
      |=> complete_q;
  endproperty
  a_complete_stands: assert property (p_complete_stands) // R11
    else $error("complete flag dropped without a control write");

endmodule // async_retry_csr_lock_regs
`default_nettype wire

// ==== rtl/retry_lock_pkg.sv ====
// constants and types shared by the retry limit and lock swap register block
//
// Overview of operation
// R1 - second bound field always reads zero
// R2 - cycle bound field always reads zero
// R3 - retry bits 15 to 12 read zero
// R4 - field 11:8 limits physical response retries
// R5 - field 7:4 limits async response retries
// R6 - field 3:0 limits async request retries
// R7 - retry register resets to all zeros
// R8 - data word stored when compare matches
// R9 - compare word checked against selected resource
// R10 - complete flag bit 31 set after swap
// R11 - control write clears flag, reset sets it
// R12 - two-bit select picks one of four resources
// R13 - control bits 30 to 2 read zero
// R14 - control write starts swap, returns prior value
// R15 - per packet retry count, give up at limit
package retry_lock_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // register byte offsets
  localparam logic [7:0] OFS_RETRY = 8'h08;
  localparam logic [7:0] OFS_DATA = 8'h0c;
  localparam logic [7:0] OFS_COMPARE = 8'h10;
  localparam logic [7:0] OFS_CONTROL = 8'h14;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h18;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h1c;

  // retry register fields
  localparam int RETRY_FIELD_W = 4;
  localparam int RETRY_WRITABLE_W = 12;
  localparam int PHYS_RESP_LSB = 8;
  localparam int ASYNC_RESP_LSB = 4;
  localparam int ASYNC_REQ_LSB = 0;
  localparam logic [31:0] RETRY_RESET = 32'h0000_0000;

  // control register fields
  localparam int COMPLETE_BIT = 31;
  localparam int SELECT_W = 2;
  localparam logic COMPLETE_RESET = 1'b1;
  localparam logic [1:0] SELECT_RESET = 2'h0;

  // lock resource selection codes and reset contents (neutral defaults)
  localparam logic [1:0] SEL_BUS_MANAGER_ID = 2'h0;
  localparam logic [1:0] SEL_BANDWIDTH_AVAILABLE = 2'h1;
  localparam logic [1:0] SEL_CHANNELS_AVAILABLE_HI = 2'h2;
  localparam logic [1:0] SEL_CHANNELS_AVAILABLE_LO = 2'h3;
  localparam logic [31:0] RESOURCE_RESET = 32'h0000_0000;

  // interrupt status bit positions
  localparam int IRQ_W = 4;
  localparam int IRQ_SWAP_DONE = 0;
  localparam int IRQ_GIVEUP_LSB = 1;

  // transmit units: 0 physical response, 1 async response, 2 async request
  localparam int NUM_UNITS = 3;

  // per-unit acknowledge events from the transmit logic
  typedef struct packed {
    logic start;
    logic busy_or_error;
    logic ack_ok;
  } tx_event_t;

  // per-unit retry decisions back to the transmit logic
  typedef struct packed {
    logic retry;
    logic give_up;
  } tx_decision_t;

  typedef enum {
    SWAP_IDLE,
    SWAP_RUN
  } swap_state_t;

  // lsb of a unit's limit field in the retry register
  function automatic int limit_lsb(input int unit);
    case (unit)
      0: limit_lsb = PHYS_RESP_LSB;
      1: limit_lsb = ASYNC_RESP_LSB;
      default: limit_lsb = ASYNC_REQ_LSB;
    endcase
  endfunction

endpackage

// ==== rtl/retry_counter.sv ====
// per-packet retry counter for one asynchronous transmit unit
`timescale 1ns/1ns
`default_nettype none
module retry_counter (
  // clock and synchronised reset
  input wire logic clock,
  input wire logic rst_n,
  // programmed limit
  input wire logic [3:0] limit,
  // acknowledge events and decisions
  input wire retry_lock_pkg::tx_event_t ev,
  output retry_lock_pkg::tx_decision_t dec,
  output logic [3:0] count
);

  logic active_q;
  logic [3:0] count_q;
  logic retry_q;
  logic give_up_q;

  // a new packet restarts the count; busy acks spend retries until the limit
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      active_q <= 1'b0;
      count_q <= 4'h0;
      retry_q <= 1'b0;
      give_up_q <= 1'b0;
    end else begin
      retry_q <= 1'b0;
      give_up_q <= 1'b0;
      if (ev.start) begin
        active_q <= 1'b1;
        count_q <= 4'h0;
      end else if (active_q && ev.ack_ok) begin
        active_q <= 1'b0;
      end else if (active_q && ev.busy_or_error) begin
        if (count_q < limit) begin // R15
          count_q <= count_q + 4'h1;
          retry_q <= 1'b1;
        end else begin
          active_q <= 1'b0; // zero limit lands here at once
          give_up_q <= 1'b1;
        end
      end
    end
  end

  assign dec.retry = retry_q;
  assign dec.give_up = give_up_q;
  assign count = count_q;

  property p_give_up_at_limit;
    @(posedge clock) disable iff (!rst_n)
    active_q && !ev.start && !ev.ack_ok && ev.busy_or_error
      && count_q >= limit |=> give_up_q && !retry_q && !active_q;
  endproperty
  a_give_up_at_limit: assert property (p_give_up_at_limit) // R15
    else $error("retry unit did not give up at its limit");

endmodule // retry_counter
`default_nettype wire

// ==== tb/tb_top.sv ====
// self-checking bench for the retry limit and lock swap register block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  typedef struct {
    logic [31:0] data;
    logic err;
    logic irq;
  } rd_note_t;

  // clock, reset and apb master
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  // transmit units, resources, interrupt
  retry_lock_pkg::tx_event_t [2:0] tx_event = '0;
  retry_lock_pkg::tx_decision_t [2:0] tx_decision;
  logic [31:0] bus_manager_id;
  logic [31:0] bandwidth_available;
  logic [31:0] channels_available_hi;
  logic [31:0] channels_available_lo;
  logic irq;

  // expectation queues and the bench's own model of the registers
  rd_note_t rd_q[$];
  logic [5:0] dec_q[$];
  int num_errors = 0;
  int compares = 0;
  logic [31:0] res_m [4];
  logic [3:0] status_m = 4'h0;
  logic [3:0] mask_m = 4'h0;
  logic [11:0] lim_m = 12'h000;

  async_retry_csr_lock_regs u_async_retry_csr_lock_regs (
    .clock(clock),
    .reset_n(reset_n),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .tx_event(tx_event),
    .tx_decision(tx_decision),
    .bus_manager_id(bus_manager_id),
    .bandwidth_available(bandwidth_available),
    .channels_available_hi(channels_available_hi),
    .channels_available_lo(channels_available_lo),
    .irq(irq)
  );

  // free running clock, 8 ns period
  always #4 clock = ~clock;

  task automatic print_verdict;
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check_val(input string what, input logic [31:0] exp,
                           input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // watcher: a completed read or a decision pulse consumes the oldest note
  always @(posedge clock) begin
    rd_note_t n;
    if (reset_n && psel && penable && pready === 1'b1 && !pwrite) begin
      if (rd_q.size() == 0) begin
        num_errors++;
        $display("[ERR] read expected none seen %h", prdata);
      end else begin
        n = rd_q.pop_front();
        check_val("prdata", n.data, prdata);
        check_val("pslverr", {31'h0, n.err}, {31'h0, pslverr});
        check_val("irq", {31'h0, n.irq}, {31'h0, irq});
      end
    end
    if (reset_n && tx_decision !== 6'h00) begin
      if (dec_q.size() == 0) begin
        num_errors++;
        $display("[ERR] tx_decision expected 00 seen %h", tx_decision);
      end else begin
        check_val("tx_decision", {26'h0, dec_q.pop_front()},
                  {26'h0, tx_decision});
      end
    end
  end

  // one apb transfer; waits on pready with a bound, never a fixed count
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      num_errors++;
      $display("[ERR] pready expected 1 seen %b", pready);
      print_verdict();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  // the interrupt level is predicted from status and mask at request time
  task automatic rd(input logic [7:0] a, input logic [31:0] d,
                    input logic e = 1'b0);
    rd_q.push_back(rd_note_t'{d, e, |(status_m & mask_m)});
    apb(1'b0, a, 32'h0000_0000);
  endtask

  // one compare-swap; the swap takes one cycle, so two edges are ample
  task automatic swap(input logic [1:0] s, input logic [31:0] d,
                      input logic [31:0] c);
    logic [31:0] prior;
    prior = res_m[s];
    wr(8'h0c, d);
    wr(8'h10, c);
    wr(8'h14, {30'h0, s});
    repeat (2) @(posedge clock);
    if (prior === c) res_m[s] = d;
    // the resource outputs settled one edge ago
    check_val("bus_manager_id", res_m[0], bus_manager_id);
    check_val("bandwidth_available", res_m[1], bandwidth_available);
    check_val("channels_available_hi", res_m[2], channels_available_hi);
    check_val("channels_available_lo", res_m[3], channels_available_lo);
    status_m[0] = 1'b1;
    rd(8'h14, {1'b1, 29'h0, s});
    rd(8'h0c, prior);
  endtask

  // one event pulse; a nonzero dec is the decision expected a cycle later
  task automatic ev(input int u, input logic [2:0] k, input logic [1:0] dec);
    logic [5:0] v;
    v = 6'h00;
    v[u*2 +: 2] = dec;
    if (dec !== 2'h0) dec_q.push_back(v);
    @(posedge clock);
    tx_event[u] <= k;
    @(posedge clock);
    tx_event[u] <= 3'h0;
  endtask

  // start, l busy answers that retry, one that gives up, then a stray busy
  task automatic packet(input int u, input int l);
    ev(u, 3'h4, 2'h0);
    for (int k = 0; k <= l; k++) ev(u, 3'h2, (k < l) ? 2'h2 : 2'h1);
    status_m[1+u] = 1'b1;
    ev(u, 3'h2, 2'h0);
  endtask

  initial begin
    logic [31:0] r;
    void'($urandom(32'h469f));
    for (int i = 0; i < 4; i++) res_m[i] = 32'h0000_0000;
    repeat (20) @(posedge clock);
    reset_n <= 1'b1;
    repeat (3) @(posedge clock);

    rd(8'h08, 32'h0000_0000);
    rd(8'h14, 32'h8000_0000);
    rd(8'h40, 32'h0000_0000, 1'b1);
    $display("test reset done");

    r = $urandom;
    wr(8'h08, r);
    rd(8'h08, {20'h0, r[11:0]});
    wr(8'h08, 32'hffff_ffff);
    rd(8'h08, 32'h0000_0fff);
    wr(8'h08, 32'h0000_0000);
    for (int u = 0; u < 3; u++) packet(u, 0);
    lim_m = {4'($urandom_range(1, 3)), 4'($urandom_range(1, 3)),
             4'($urandom_range(1, 3))};
    wr(8'h08, {20'h0, lim_m});
    for (int u = 0; u < 3; u++)
      packet(u, int'(lim_m[(2-u)*4 +: 4]));
    // an ok answer ends the packet, so a later busy goes unanswered
    ev(1, 3'h4, 2'h0);
    ev(1, 3'h2, 2'h2);
    ev(1, 3'h1, 2'h0);
    ev(1, 3'h2, 2'h0);
    $display("test retry done");

    for (int s = 0; s < 4; s++) begin
      r = $urandom;
      swap(2'(s), r, 32'h0000_0000);
      swap(2'(s), ~r, ~r);
      swap(2'(s), $urandom, r);
    end
    $display("test swap done");

    rd(8'h18, {28'h0, status_m});
    wr(8'h1c, 32'h0000_000f);
    mask_m = 4'hf;
    rd(8'h1c, 32'h0000_000f);
    wr(8'h18, {28'h0, status_m});
    status_m = 4'h0;
    rd(8'h18, 32'h0000_0000);
    wr(8'h1c, 32'h0000_0001);
    mask_m = 4'h1;
    packet(2, int'(lim_m[3:0]));
    rd(8'h18, 32'h0000_0008);
    swap(2'h1, 32'h0000_00a5, res_m[1]);
    wr(8'h18, 32'h0000_0009);
    status_m = 4'h0;
    wr(8'h40, 32'hffff_ffff);
    rd(8'h40, 32'h0000_0000, 1'b1);
    $display("test interrupt done");

    repeat (5) @(posedge clock);
    if (rd_q.size() != 0 || dec_q.size() != 0) begin
      num_errors++;
      $display("[ERR] pending notes expected 0 seen %0d",
               rd_q.size() + dec_q.size());
    end
    print_verdict();
  end
endmodule // tb_top
`default_nettype wire
